// *** hdl/fpd_cmd.v ***
// serial flash power-down, identification, parameter table and security register command block
//
// Contract
// - sleep opcode acts only when select rises right after its eighth bit.
// - asleep, only the wake/ID opcode is recognised; all others ignored.
// - after a valid sleep command the device is asleep within the entry time.
// - after reset the device is awake, never asleep.
// - wake opcode alone, select high, commands accepted again after wake time.
// - wake opcode plus three dummy bytes streams device id, msb first, repeating.
// - wake with id read waits the longer wake-with-id time before commands.
// - wake/ID opcode ignored while busy; ongoing operation untouched.
// - opcode 90h, address 0 gives manufacturer first, address 1 device first, alternating.
// - identity opcode outputs manufacturer, type, capacity bytes msb first.
// - parameter read starts output at the falling edge of the 40th clock.
// - three separate 1024-byte security registers outside the main array.
// - security erase needs the write latch set.
// - address 23..16 zero, 15..12 selects 1..3, 11..10 zero, 9..0 byte.
// - security erase runs only if select rises right after the address.
// - erase is self-timed, busy high throughout; status reads still served.
// - erase completion clears the write latch.
// - a set lock bit makes its register permanent; erase to it ignored.
// - security program needs write latch, opcode, address, at least one byte.
// - program takes one to 1024 bytes into erased locations.
// - program to a locked security register is ignored.
// - software reset is not allowed while asleep or still waking.
`timescale 1ns/10ps
`include "fpd_map.vh"

module fpd_cmd #(
  parameter AW = 8,
  parameter ERASE_CYC = `FPD_ERASE_NS / `FPD_CLK_NS
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // serial link pins
  input wire sclk,
  input wire cs_n,
  input wire serial_in,
  output wire serial_out,
  output wire serial_out_oe_n,
  // status interface to the rest of the device
  input wire ext_busy,
  input wire wel_set,
  input wire wel_clr,
  input wire quad_command_mode,
  output wire busy,
  output wire write_latch_flag,
  output wire [3:1] otp_lock_bits,
  output wire deep_sleep,
  output wire status_read_ok,
  output wire sw_reset_ok
);

  localparam [15:0] SLEEP_CYC = `FPD_SLEEP_ENTRY_NS / `FPD_CLK_NS;
  localparam [15:0] WAKE_CYC = `FPD_WAKE_NS / `FPD_CLK_NS;
  localparam [15:0] WAKE_ID_CYC = `FPD_WAKE_ID_NS / `FPD_CLK_NS;
  localparam [15:0] PROG_CYC = `FPD_PROG_NS / `FPD_CLK_NS;
  localparam [15:0] ERASE_CYC16 = ERASE_CYC;
  localparam SEC_DEPTH = `FPD_SEC_BYTES * 4;

  // security register with address check; returns 0 when the address is out of range
  function [1:0] sec_sel;
    input [23:0] a;
    begin
      if (a[23:16] == 8'h00 && a[11:10] == 2'h0 && a[15:12] >= 4'h1 && a[15:12] <= 4'h3) begin
        sec_sel = a[13:12];
      end else begin
        sec_sel = 2'h0;
      end
    end
  endfunction

  // first output bit position per opcode
  function [15:0] out_start;
    input [7:0] op;
    input qmode;
    begin
      case (op)
        `FPD_OP_WAKE: out_start = `FPD_POS_ID_START;
        `FPD_OP_MFR_DEV: out_start = `FPD_POS_ID_START;
        `FPD_OP_IDENT: out_start = `FPD_POS_IDENT_START;
        `FPD_OP_IDENT_ALT: out_start = qmode ? `FPD_POS_IDENT_START : `FPD_POS_NONE;
        `FPD_OP_PARAM: out_start = `FPD_POS_PARAM_START;
        default: out_start = `FPD_POS_NONE;
      endcase
    end
  endfunction

  // pin synchronisers; stage 3 only feeds the edge detectors
  reg sck_s1_ff, sck_s2_ff, sck_s3_ff;
  reg cs_s1_ff, cs_s2_ff, cs_s3_ff;
  reg si_s1_ff, si_s2_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_s3_ff <= 1'b0;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
      si_s1_ff <= 1'b0;
      si_s2_ff <= 1'b0;
    end else begin
      sck_s1_ff <= sclk;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
      cs_s1_ff <= cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      si_s1_ff <= serial_in;
      si_s2_ff <= si_s1_ff;
    end
  end

  wire sck_rise = sck_s2_ff & ~sck_s3_ff & ~cs_s2_ff;
  wire sck_fall = ~sck_s2_ff & sck_s3_ff & ~cs_s2_ff;
  wire cs_rise = cs_s2_ff & ~cs_s3_ff;

  // state and storage
  reg [15:0] bit_cnt_ff;
  reg [7:0] sh_ff;
  reg [7:0] op_ff;
  reg [23:0] addr_ff;
  reg cmd_en_ff;
  reg [4:0] state_ff;
  reg [15:0] tmr_ff;
  reg sleep_ff;
  reg wel_ff;
  reg [3:1] lock_ff;
  reg [7:0] out_sh_ff;
  reg so_ff;
  reg out_en_ff;
  reg [7:0] byte_cnt_ff;
  reg [1:0] id3_ff;
  reg prog_ok_ff;
  reg prog_any_ff;
  reg [1:0] prog_sel_ff;
  reg [9:0] prog_ptr_ff;
  reg [1:0] erase_sel_ff;
  reg [9:0] sweep_ff;
  reg sweep_on_ff;
  reg [7:0] sec_mem [0:SEC_DEPTH-1];
  reg [7:0] param_mem [0:255];
  reg [31:0] ident_ff;
  reg [7:0] param_ptr_ff;
  reg [11:0] sec_ptr_ff;

  wire [15:0] bit_nxt = bit_cnt_ff + 16'h0001;
  wire [7:0] byte_in = {sh_ff[6:0], si_s2_ff};
  wire [23:0] addr_in = {addr_ff[22:0], si_s2_ff};
  wire op_busy = (state_ff == `FPD_ST_ERASE) || (state_ff == `FPD_ST_PROG);
  wire waking = (state_ff == `FPD_ST_WAKE);
  wire busy_all = op_busy | ext_busy;
  wire [7:0] op_now = byte_in;
  wire [1:0] sel_in = sec_sel(addr_in);
  wire [1:0] sel_cur = sec_sel(addr_ff);

  // opcode acceptance: asleep only wake/ID, wake/ID refused while busy, nothing while waking
  wire accept_now = ~waking & (sleep_ff ? (op_now == `FPD_OP_WAKE) :
                    ~((op_now == `FPD_OP_WAKE) & busy_all));

  // serial shifter: bit count, opcode, address
  always @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_ff <= 16'h0000;
      sh_ff <= 8'h00;
      op_ff <= 8'h00;
      addr_ff <= 24'h000000;
      cmd_en_ff <= 1'b0;
    end else if (cs_s2_ff) begin
      bit_cnt_ff <= 16'h0000;
      cmd_en_ff <= 1'b0;
    end else if (sck_rise) begin
      if (bit_cnt_ff != 16'hFFFF) begin
        bit_cnt_ff <= bit_nxt;
      end
      sh_ff <= byte_in;
      if (bit_nxt == `FPD_POS_OPCODE) begin
        op_ff <= op_now;
        cmd_en_ff <= accept_now;
      end
      if (bit_cnt_ff >= `FPD_POS_OPCODE && bit_cnt_ff < `FPD_POS_ADDR_END) begin
        addr_ff <= addr_in;
      end
    end
  end

  // byte to be shifted out next
  reg [7:0] out_byte;
  always @* begin
    case (op_ff)
      `FPD_OP_WAKE: out_byte = ident_ff[31:24];
      `FPD_OP_MFR_DEV: out_byte = (byte_cnt_ff[0] ^ addr_ff[0]) ? ident_ff[31:24] : ident_ff[7:0];
      `FPD_OP_PARAM: out_byte = param_mem[addr_ff[7:0] + byte_cnt_ff];
      default: out_byte = (id3_ff == 2'h0) ? ident_ff[7:0] :
                          (id3_ff == 2'h1) ? ident_ff[15:8] : ident_ff[23:16];
    endcase
  end

  // output shifter: new byte on the fall after each 8th rise from the start position
  wire [15:0] start_pos = out_start(op_ff, quad_command_mode);
  wire load_byte = sck_fall & cmd_en_ff & (bit_cnt_ff >= start_pos) &
                   (bit_cnt_ff[2:0] == 3'h0) & (start_pos != `FPD_POS_NONE);
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_sh_ff <= 8'h00;
      so_ff <= 1'b0;
      out_en_ff <= 1'b0;
      byte_cnt_ff <= 8'h00;
      id3_ff <= 2'h0;
    end else if (cs_s2_ff) begin
      out_en_ff <= 1'b0;
      byte_cnt_ff <= 8'h00;
      id3_ff <= 2'h0;
    end else if (load_byte) begin
      out_sh_ff <= {out_byte[6:0], 1'b0};
      so_ff <= out_byte[7];
      out_en_ff <= 1'b1;
      byte_cnt_ff <= byte_cnt_ff + 8'h01;
      id3_ff <= (id3_ff == 2'h2) ? 2'h0 : id3_ff + 2'h1;
    end else if (sck_fall && out_en_ff) begin
      so_ff <= out_sh_ff[7];
      out_sh_ff <= {out_sh_ff[6:0], 1'b0};
    end
  end

  // program qualification at the last address bit, then byte writes into the register
  wire prog_qual = cmd_en_ff & (op_ff == `FPD_OP_SEC_PROG) & wel_ff & ~busy_all &
                   (sel_in != 2'h0) & ~lock_ff[sel_in];
  wire prog_wr = sck_rise & prog_ok_ff & (bit_nxt >= `FPD_POS_FIRST_DATA) & (bit_nxt[2:0] == 3'h0);
  always @(posedge aclk) begin
    if (!aresetn) begin
      prog_ok_ff <= 1'b0;
      prog_any_ff <= 1'b0;
      prog_sel_ff <= 2'h0;
      prog_ptr_ff <= 10'h000;
    end else if (cs_s2_ff) begin
      prog_ok_ff <= 1'b0;
      prog_any_ff <= 1'b0;
    end else if (sck_rise && bit_nxt == `FPD_POS_ADDR_END) begin
      prog_ok_ff <= prog_qual;
      prog_sel_ff <= sel_in;
      prog_ptr_ff <= addr_in[9:0];
    end else if (prog_wr) begin
      prog_any_ff <= 1'b1;
      prog_ptr_ff <= prog_ptr_ff + 10'h001;
    end
  end

  // security register array; programming can only clear bits, erase fills with ones
  always @(posedge aclk) begin
    if (sweep_on_ff) begin
      sec_mem[{erase_sel_ff, sweep_ff}] <= 8'hFF;
    end else if (prog_wr) begin
      sec_mem[{prog_sel_ff, prog_ptr_ff}] <= sec_mem[{prog_sel_ff, prog_ptr_ff}] & byte_in;
    end
  end

  // actions taken when select rises; sleep and erase only at their exact bit count, wake and program at any bit
  wire go_sleep = cs_rise & cmd_en_ff & (op_ff == `FPD_OP_SLEEP) & (bit_cnt_ff == `FPD_POS_OPCODE);
  wire go_wake = cs_rise & cmd_en_ff & (op_ff == `FPD_OP_WAKE) & sleep_ff;
  wire go_erase = cs_rise & cmd_en_ff & (op_ff == `FPD_OP_SEC_ERASE) &
                  (bit_cnt_ff == `FPD_POS_ADDR_END) & wel_ff & ~busy_all &
                  (sel_cur != 2'h0) & ~lock_ff[sel_cur];
  wire go_prog = cs_rise & prog_ok_ff & prog_any_ff;
  wire tmr_done = (tmr_ff == 16'h0001);
  wire op_done = op_busy & tmr_done;

  // power and operation sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= `FPD_ST_IDLE;
      tmr_ff <= 16'h0000;
      sleep_ff <= 1'b0;
      sweep_on_ff <= 1'b0;
      sweep_ff <= 10'h000;
      erase_sel_ff <= 2'h0;
    end else begin
      if (sweep_on_ff) begin
        sweep_ff <= sweep_ff + 10'h001;
        sweep_on_ff <= (sweep_ff != 10'h3FF);
      end
      case (state_ff)
        `FPD_ST_IDLE: begin
          if (go_sleep && !sleep_ff) begin
            state_ff <= `FPD_ST_ENTER;
            tmr_ff <= SLEEP_CYC;
          end else if (go_wake) begin
            state_ff <= `FPD_ST_WAKE;
            tmr_ff <= (bit_cnt_ff >= `FPD_POS_ID_START) ? WAKE_ID_CYC : WAKE_CYC;
          end else if (go_erase) begin
            state_ff <= `FPD_ST_ERASE;
            tmr_ff <= ERASE_CYC16;
            erase_sel_ff <= sel_cur;
            sweep_ff <= 10'h000;
            sweep_on_ff <= 1'b1;
          end else if (go_prog) begin
            state_ff <= `FPD_ST_PROG;
            tmr_ff <= PROG_CYC;
          end
        end
        `FPD_ST_ENTER: begin
          tmr_ff <= tmr_ff - 16'h0001;
          if (tmr_done) begin
            sleep_ff <= 1'b1;
            state_ff <= `FPD_ST_IDLE;
          end
        end
        `FPD_ST_WAKE: begin
          tmr_ff <= tmr_ff - 16'h0001;
          if (tmr_done) begin
            sleep_ff <= 1'b0;
            state_ff <= `FPD_ST_IDLE;
          end
        end
        `FPD_ST_ERASE, `FPD_ST_PROG: begin
          tmr_ff <= tmr_ff - 16'h0001;
          if (tmr_done) begin
            state_ff <= `FPD_ST_IDLE;
          end
        end
        default: begin
          state_ff <= `FPD_ST_IDLE;
        end
      endcase
    end
  end

  // axi write channel: address and data are held independently, response after both
  reg aw_hold_ff, w_hold_ff, bvalid_ff;
  reg [AW-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [1:0] bresp_ff;
  wire do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire [7:0] wa = awaddr_ff[7:0];
  wire wr_ctrl = do_write & (wa == `FPD_REG_CTRL) & wstrb_ff[0];
  wire wr_known = (wa == `FPD_REG_CTRL) || (wa == `FPD_REG_STATUS) || (wa == `FPD_REG_LOCK) ||
                  (wa == `FPD_REG_IDENT) || (wa == `FPD_REG_PARAM_PTR) || (wa == `FPD_REG_PARAM_DATA) ||
                  (wa == `FPD_REG_SEC_PTR) || (wa == `FPD_REG_SEC_DATA);
  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `FPD_RESP_OKAY;
      awaddr_ff <= {AW{1'b0}};
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? `FPD_RESP_OKAY : `FPD_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // software-visible state: write latch, lock bits, identity bytes, table and pointers
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      wel_ff <= 1'b0;
      lock_ff <= 3'h0;
      ident_ff <= {`FPD_RST_DEV_ID, `FPD_RST_CAP_ID, `FPD_RST_TYPE_ID, `FPD_RST_MFR_ID};
      param_ptr_ff <= 8'h00;
      sec_ptr_ff <= 12'h000;
    end else begin
      // a set in the same cycle as any clear wins
      if (wel_set || (wr_ctrl && wdata_ff[`FPD_CTRL_WEL_SET])) begin
        wel_ff <= 1'b1;
      end else if (wel_clr || op_done || (wr_ctrl && wdata_ff[`FPD_CTRL_WEL_CLR])) begin
        wel_ff <= 1'b0;
      end
      if (do_write && wa == `FPD_REG_LOCK && wstrb_ff[0]) begin
        lock_ff <= lock_ff | wdata_ff[3:1];
      end
      if (do_write && wa == `FPD_REG_IDENT) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (wstrb_ff[i]) begin
            ident_ff[i*8 +: 8] <= wdata_ff[i*8 +: 8];
          end
        end
      end
      if (do_write && wa == `FPD_REG_PARAM_PTR && wstrb_ff[0]) begin
        param_ptr_ff <= wdata_ff[7:0];
      end else if (do_write && wa == `FPD_REG_PARAM_DATA && wstrb_ff[0]) begin
        param_ptr_ff <= param_ptr_ff + 8'h01;
      end
      if (do_write && wa == `FPD_REG_SEC_PTR && wstrb_ff[0] && wstrb_ff[1]) begin
        sec_ptr_ff <= wdata_ff[11:0];
      end
    end
  end

  // table fill from software, one byte per write, pointer steps after each
  always @(posedge aclk) begin
    if (do_write && wa == `FPD_REG_PARAM_DATA && wstrb_ff[0]) begin
      param_mem[param_ptr_ff] <= wdata_ff[7:0];
    end
  end

  // axi read channel: one outstanding read, answered the cycle after it is taken
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [31:0] rd_mux;
  reg rd_ok;
  wire [7:0] ra = s_axi_araddr[7:0];
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always @* begin
    rd_ok = 1'b1;
    case (ra)
      `FPD_REG_CTRL: rd_mux = 32'h00000000;
      `FPD_REG_STATUS: rd_mux = {26'h0000000, (state_ff == `FPD_ST_PROG), (state_ff == `FPD_ST_ERASE),
                                 waking, sleep_ff, wel_ff, busy_all};
      `FPD_REG_LOCK: rd_mux = {28'h0000000, lock_ff, 1'b0};
      `FPD_REG_IDENT: rd_mux = ident_ff;
      `FPD_REG_PARAM_PTR: rd_mux = {24'h000000, param_ptr_ff};
      `FPD_REG_PARAM_DATA: rd_mux = {24'h000000, param_mem[param_ptr_ff]};
      `FPD_REG_SEC_PTR: rd_mux = {20'h00000, sec_ptr_ff};
      `FPD_REG_SEC_DATA: rd_mux = {24'h000000, sec_mem[sec_ptr_ff]};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `FPD_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_ok ? `FPD_RESP_OKAY : `FPD_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // pins and status interface; outputs settle two to three clocks behind the link edges
  assign serial_out = so_ff;
  assign serial_out_oe_n = ~out_en_ff;
  assign busy = busy_all;
  assign write_latch_flag = wel_ff;
  assign otp_lock_bits = lock_ff;
  assign deep_sleep = sleep_ff;
  assign status_read_ok = ~sleep_ff & ~waking;
  assign sw_reset_ok = ~sleep_ff & ~waking;

endmodule // fpd_cmd

// *** inc/fpd_map.vh ***
// opcodes, bit positions, timings, register map and reset values of the flash command block
`ifndef FPD_MAP_VH
`define FPD_MAP_VH
// serial opcodes
`define FPD_OP_SLEEP 8'hB9
`define FPD_OP_WAKE 8'hAB
`define FPD_OP_MFR_DEV 8'h90
`define FPD_OP_IDENT 8'h9F
`define FPD_OP_IDENT_ALT 8'hAF
`define FPD_OP_PARAM 8'h5A
`define FPD_OP_SEC_ERASE 8'h44
`define FPD_OP_SEC_PROG 8'h42
// rising-edge counts on the serial clock
`define FPD_POS_OPCODE 16'h0008
`define FPD_POS_ADDR_END 16'h0020
`define FPD_POS_ID_START 16'h0020
`define FPD_POS_IDENT_START 16'h0008
`define FPD_POS_PARAM_START 16'h0028
`define FPD_POS_FIRST_DATA 16'h0028
`define FPD_POS_NONE 16'hFFFF
// timing in ns, clock period in ns
`define FPD_CLK_NS 5
`define FPD_SLEEP_ENTRY_NS 3000
`define FPD_WAKE_NS 3000
`define FPD_WAKE_ID_NS 5000
`define FPD_ERASE_NS 50000
`define FPD_PROG_NS 20000
// security register geometry
`define FPD_SEC_BYTES 1024
`define FPD_SEC_COUNT 3
// controller states, one-hot
`define FPD_ST_IDLE 5'h01
`define FPD_ST_ENTER 5'h02
`define FPD_ST_WAKE 5'h04
`define FPD_ST_ERASE 5'h08
`define FPD_ST_PROG 5'h10
// register byte offsets
`define FPD_REG_CTRL 8'h00
`define FPD_REG_STATUS 8'h04
`define FPD_REG_LOCK 8'h08
`define FPD_REG_IDENT 8'h0C
`define FPD_REG_PARAM_PTR 8'h10
`define FPD_REG_PARAM_DATA 8'h14
`define FPD_REG_SEC_PTR 8'h18
`define FPD_REG_SEC_DATA 8'h1C
// field positions
`define FPD_CTRL_WEL_SET 0
`define FPD_CTRL_WEL_CLR 1
`define FPD_ST_BUSY_BIT 0
`define FPD_ST_WEL_BIT 1
`define FPD_ST_SLEEP_BIT 2
`define FPD_ST_WAKING_BIT 3
`define FPD_ST_ERASING_BIT 4
`define FPD_ST_PROGRAMMING_BIT 5
// identity reset values (arbitrary, neutral)
`define FPD_RST_MFR_ID 8'h5E
`define FPD_RST_TYPE_ID 8'h40
`define FPD_RST_CAP_ID 8'h18
`define FPD_RST_DEV_ID 8'h17
`define FPD_RESP_OKAY 2'h0
`define FPD_RESP_SLVERR 2'h2
`endif

// *** tb/fpd_cmd_props.sv ***
// concurrent checks on the flash command block ports
`timescale 1ns/10ps
module fpd_cmd_chk (
  // clock, reset, bus handshakes
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // link and status
  input wire cs_n,
  input wire serial_out_oe_n,
  input wire ext_busy,
  input wire wel_set,
  input wire busy,
  input wire write_latch_flag,
  input wire deep_sleep,
  input wire status_read_ok,
  input wire sw_reset_ok
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers within the promised cycles
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  // power state and status gating
  a_awake_reset: assert property ($rose(aresetn) |-> !deep_sleep && !write_latch_flag)
    else $error("asleep after reset");
  a_sleep_blocks: assert property (deep_sleep |-> !status_read_ok) else $error("status served asleep");
  a_swreset_gate: assert property (!status_read_ok |-> !sw_reset_ok) else $error("reset open asleep");
  // busy and write latch relations
  a_busy_ext: assert property (ext_busy |-> busy) else $error("busy lost");
  a_busy_needs_wel: assert property ($rose(busy) && !ext_busy |-> $past(write_latch_flag))
    else $error("busy without latch");
  a_done_clears: assert property ($fell(busy) && !$past(ext_busy) && !wel_set |-> ##[0:1] !write_latch_flag)
    else $error("latch kept after done");
  // output released once select has been high a while
  a_oe_idle: assert property (cs_n [*8] |-> serial_out_oe_n) else $error("driving while deselected");
endmodule // fpd_cmd_chk
bind fpd_cmd fpd_cmd_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .cs_n, .serial_out_oe_n, .ext_busy, .wel_set,
  .busy, .write_latch_flag, .deep_sleep, .status_read_ok, .sw_reset_ok);

// *** tb/fpd_host.sv ***
// serial host model that drives frames into the flash command block
`timescale 1ns/10ps
module fpd_host (
  // link pins toward the device
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  // answer from the device
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // clock rests low between frames, select idle high
  initial begin
    sclk = 0;
    cs_n = 1;
    serial_in = 1;
  end
  // mode 0: bits out msb first, answer sampled on rising edges, 64 ns period
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [31:0] rx, output logic drv);
    rx = 32'h0;
    drv = 0;
    cs_n = 0;
    #32;
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx) serial_in = tx[63-i];
      #32 sclk = 1;
      if (i >= ntx) rx = {rx[30:0], serial_out_oe_n | serial_out}; // released line reads pulled up
      if (i >= ntx && !serial_out_oe_n) drv = 1;
      #32 sclk = 0;
    end
    // select rises right at the last counted bit
    #32 cs_n = 1;
    serial_in = ~serial_in;
    #200;
  endtask
endmodule // fpd_host

// *** tb/tb_fpd_cmd.sv ***
// self-checking bench for the flash command block
`timescale 1ns/10ps
`include "fpd_map.vh"
module tb_fpd_cmd;
  logic aclk = 0, aresetn = 0, sclk, cs_n, serial_in, serial_out, serial_out_oe_n, drv;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rx;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ext_busy = 0, wel_set = 0, wel_clr = 0, quad_command_mode = 0;
  logic busy, write_latch_flag, deep_sleep, status_read_ok, sw_reset_ok;
  logic [3:1] otp_lock_bits;
  int errors = 0, tests_run = 0, cyc = 0;
  localparam logic [7:0] M = `FPD_RST_MFR_ID, D = `FPD_RST_DEV_ID;
  // short erase keeps the run small; program stays at 4000 cycles
  fpd_cmd #(.ERASE_CYC(1100)) i_dut (.*);
  fpd_host i_host (.sclk, .cs_n, .serial_in, .serial_out, .serial_out_oe_n);
  initial forever #2.5 aclk = ~aclk;
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // outputs are read a little after the edge so they have settled
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // handshakes sampled at the falling edge, released after the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    b = 1;
    while (b) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) begin
        s_axi_bready <= 0;
        b = 0;
        chk(r, er);
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    t = 0;
    while (!t) begin
      @(negedge aclk);
      ta = s_axi_arready;
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    chk(d, ed);
    chk(r, er);
  endtask
  task automatic fr(input logic [63:0] tx, input int n, input int m);
    i_host.frame(tx, n, m, rx, drv);
  endtask
  task automatic nap();
    fr({`FPD_OP_SLEEP, 56'h0}, 8, 0);
    wt(700);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    wt(5);
    rd(`FPD_REG_IDENT, {D, `FPD_RST_CAP_ID, `FPD_RST_TYPE_ID, M}, `FPD_RESP_OKAY);
    rd(`FPD_REG_STATUS, 32'h0, `FPD_RESP_OKAY);
    rd(8'h20, 32'h0, `FPD_RESP_SLVERR);
    wr(8'hFC, 32'h1, `FPD_RESP_SLVERR);
    ext_busy <= 1;
    wel_set <= 1;
    wel_clr <= 1;
    wt(1);
    chk(busy, 1);
    chk(write_latch_flag, 1);
    @(posedge aclk) ext_busy <= 0;
    wel_set <= 0;
    wt(1);
    chk(write_latch_flag, 0);
    @(posedge aclk) wel_clr <= 0;
    done("regs");
    // both identity opcodes, the alternate one in four-wire command mode
    quad_command_mode <= 1;
    for (int k = 0; k < 2; k++) begin
      fr({k ? `FPD_OP_IDENT_ALT : `FPD_OP_IDENT, 56'h0}, 8, 24);
      chk(rx[23:0], {M, `FPD_RST_TYPE_ID, `FPD_RST_CAP_ID});
      fr({`FPD_OP_MFR_DEV, 23'h0, k[0], 32'h0}, 32, 32);
      chk(rx, k ? {D, M, D, M} : {M, D, M, D});
    end
    // the alternate opcode is not an identity read outside four-wire command mode
    @(posedge aclk) quad_command_mode <= 0;
    fr({`FPD_OP_IDENT_ALT, 56'h0}, 8, 8);
    chk(drv, 0);
    fr({`FPD_OP_WAKE, 56'h0}, 32, 16);
    chk(rx[15:0], {D, D});
    wt(1100);
    wr(`FPD_REG_PARAM_PTR, 32'h10, `FPD_RESP_OKAY);
    wr(`FPD_REG_PARAM_DATA, 32'hA5, `FPD_RESP_OKAY);
    wr(`FPD_REG_PARAM_DATA, 32'h3C, `FPD_RESP_OKAY);
    fr({`FPD_OP_PARAM, 24'h10, 32'h0}, 40, 16);
    chk(rx[15:0], 16'hA53C);
    done("ident");
    // nine bits is not a sleep command
    fr({`FPD_OP_SLEEP, 56'h0}, 9, 0);
    wt(700);
    chk(deep_sleep, 0);
    nap();
    chk(deep_sleep, 1);
    chk(sw_reset_ok, 0);
    fr({`FPD_OP_IDENT, 56'h0}, 8, 24);
    chk(drv, 0);
    fr({`FPD_OP_WAKE, 56'h0}, 8, 0);
    wt(300);
    chk(status_read_ok, 0);
    wt(400);
    chk(status_read_ok, 1);
    nap();
    fr({`FPD_OP_WAKE, 56'h0}, 32, 8);
    chk(rx[7:0], D);
    wt(700);
    chk(status_read_ok, 0);
    wt(400);
    chk(status_read_ok, 1);
    done("sleep");
    fr({`FPD_OP_SEC_ERASE, 24'h001000, 32'h0}, 32, 0);
    chk(busy, 0);
    wr(`FPD_REG_CTRL, 32'h1, `FPD_RESP_OKAY);
    fr({`FPD_OP_SEC_ERASE, 24'h004000, 32'h0}, 32, 0);
    chk(busy, 0);
    fr({`FPD_OP_SEC_ERASE, 24'h001000, 32'h0}, 33, 0);
    chk(busy, 0);
    fr({`FPD_OP_SEC_ERASE, 24'h001000, 32'h0}, 32, 0);
    rd(`FPD_REG_STATUS, 32'h13, `FPD_RESP_OKAY);
    fr({`FPD_OP_WAKE, 56'h0}, 32, 8);
    chk({drv, busy}, 2'b01);
    wt(1100);
    chk({busy, write_latch_flag}, 2'b00);
    // a locked register refuses erase and program
    wr(`FPD_REG_LOCK, 32'h4, `FPD_RESP_OKAY);
    chk(otp_lock_bits, 3'b010);
    wr(`FPD_REG_CTRL, 32'h1, `FPD_RESP_OKAY);
    fr({`FPD_OP_SEC_ERASE, 24'h002000, 32'h0}, 32, 0);
    chk(busy, 0);
    fr({`FPD_OP_SEC_PROG, 24'h002000, 8'h5A, 24'h0}, 40, 0);
    chk(busy, 0);
    fr({`FPD_OP_SEC_PROG, 24'h001005, 8'hA5, 24'h0}, 40, 0);
    chk(busy, 1);
    wt(4100);
    chk({busy, write_latch_flag}, 2'b00);
    wr(`FPD_REG_SEC_PTR, 32'h404, `FPD_RESP_OKAY);
    rd(`FPD_REG_SEC_DATA, 32'hFF, `FPD_RESP_OKAY);
    wr(`FPD_REG_SEC_PTR, 32'h405, `FPD_RESP_OKAY);
    rd(`FPD_REG_SEC_DATA, 32'hA5, `FPD_RESP_OKAY);
    done("secreg");
    complete_run();
  end
endmodule // tb_fpd_cmd
